// [hdl/pops_defines.svh]
// shared constants for the parallel output port block
// assumes inclusion by bare name from hdl/ files
`ifndef POPS_DEFINES_SVH
`define POPS_DEFINES_SVH

`define POPS_DATA_W 16
`define POPS_CHAN_W 3
`define POPS_NUM_PORTS 3
`define POPS_SYNC_STAGES 2
`define POPS_WORD_W 21

`endif

// [hdl/pops_pkg.sv]
// types for the parallel output port block
// assumes pops_defines.svh is on the include path
`include "pops_defines.svh"
package pops_pkg;
	typedef enum logic [2:0] {
		POPS_IDLE = 3'b001,
		POPS_REQ = 3'b010,
		POPS_DONE = 3'b100
	} pops_link_state_e;
	typedef logic [`POPS_WORD_W-1:0] pops_word_t;
endpackage

// [hdl/pops_sync.sv]
// two-flop level synchroniser
// assumes din is asynchronous to clk
`timescale 1ns/1ps
module pops_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// [hdl/pops_port.sv]
// one output port: word handshake toward receiver on the port clock
// assumes core side holds word until its toggle is answered
`timescale 1ns/1ps
`include "pops_defines.svh"
module pops_port (
	input wire logic pclk,
	input wire logic prst,
	input wire logic load_toggle,
	input wire logic [`POPS_WORD_W-1:0] load_word,
	output logic done_toggle,
	output logic [`POPS_DATA_W-1:0] data_bus,
	output logic [`POPS_CHAN_W-1:0] channel_tag,
	output logic inphase_flag,
	output logic gain_word_flag,
	output logic request,
	input wire logic acknowledge
);
	logic load_sync;
	logic load_seen;
	logic ack_s;
	pops_pkg::pops_link_state_e state;

	pops_sync #(.WIDTH(2)) u_sync (
		.clk(pclk),
		.rst(prst),
		.din({load_toggle, acknowledge}),
		.dout({load_sync, ack_s})
	);

	// ------------------------------------------------------------
	// handshake on the port clock
	// ------------------------------------------------------------
	always_ff @(posedge pclk or posedge prst) begin
		if (prst) begin
			state <= pops_pkg::POPS_IDLE;
			load_seen <= 1'b0;
			done_toggle <= 1'b0;
			request <= 1'b0;
			data_bus <= '0;
			channel_tag <= '0;
			inphase_flag <= 1'b0;
			gain_word_flag <= 1'b0;
		end else begin
			unique case (state)
				pops_pkg::POPS_IDLE: begin
					if (load_sync != load_seen && !ack_s) begin
						load_seen <= load_sync;
						// word stable in core while toggle pending
						{gain_word_flag, inphase_flag, channel_tag,
							data_bus} <= load_word;
						request <= 1'b1;
						state <= pops_pkg::POPS_REQ;
					end
				end
				pops_pkg::POPS_REQ: begin
					// outputs frozen until ack sampled high
					if (ack_s) begin
						request <= 1'b0;
						done_toggle <= ~done_toggle;
						state <= pops_pkg::POPS_DONE;
					end
				end
				pops_pkg::POPS_DONE: begin
					state <= pops_pkg::POPS_IDLE;
				end
			endcase
		end
	end
endmodule

// [hdl/pops_top.sv]
// three parallel output ports with shared port clock
// assumes core producers hold valid until ready; pclk_in is from the pin
`timescale 1ns/1ps
`include "pops_defines.svh"
module pops_top #(
	parameter int CLK_DIV = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic master_mode,
	input wire logic pclk_in,
	output logic pclk_out,
	output logic pclk_oe,
	input wire logic [`POPS_NUM_PORTS-1:0] word_valid,
	output logic [`POPS_NUM_PORTS-1:0] word_ready,
	input wire logic [`POPS_NUM_PORTS*`POPS_DATA_W-1:0] word_data,
	input wire logic [`POPS_NUM_PORTS*`POPS_CHAN_W-1:0] word_channel,
	input wire logic [`POPS_NUM_PORTS-1:0] word_inphase,
	input wire logic [`POPS_NUM_PORTS-1:0] word_gain,
	output logic [`POPS_DATA_W-1:0] port_a_data_bus,
	output logic [`POPS_CHAN_W-1:0] port_a_channel_tag,
	output logic port_a_inphase_flag,
	output logic port_a_gain_word_flag,
	output logic port_a_request,
	input wire logic port_a_acknowledge,
	output logic [`POPS_DATA_W-1:0] port_b_data_bus,
	output logic [`POPS_CHAN_W-1:0] port_b_channel_tag,
	output logic port_b_inphase_flag,
	output logic port_b_gain_word_flag,
	output logic port_b_request,
	input wire logic port_b_acknowledge,
	output logic [`POPS_DATA_W-1:0] port_c_data_bus,
	output logic [`POPS_CHAN_W-1:0] port_c_channel_tag,
	output logic port_c_inphase_flag,
	output logic port_c_gain_word_flag,
	output logic port_c_request,
	input wire logic port_c_acknowledge
);
	localparam int NP = `POPS_NUM_PORTS;
	localparam int DW = `POPS_DATA_W;
	localparam int CW = `POPS_CHAN_W;

	logic mode_s;
	logic [7:0] div_cnt;
	logic div_clk;
	logic pclk;
	logic prst_meta;
	logic prst;
	logic [NP-1:0] load_toggle;
	logic [NP-1:0] done_toggle;
	logic [NP-1:0] done_s;
	logic [NP-1:0] done_seen;
	logic [NP-1:0] busy;
	pops_pkg::pops_word_t hold_word [NP];
	logic [DW-1:0] bus_d [NP];
	logic [CW-1:0] tag_d [NP];
	logic [NP-1:0] iq_d;
	logic [NP-1:0] gain_d;
	logic [NP-1:0] req_d;
	logic [NP-1:0] ack_d;

	// ------------------------------------------------------------
	// port clock: divider out in master, pin in slave
	// ------------------------------------------------------------
	pops_sync #(.WIDTH(1)) u_mode (
		.clk(clk),
		.rst(rst),
		.din(master_mode),
		.dout(mode_s)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 8'h00;
			div_clk <= 1'b0;
		end else if (div_cnt == 8'(CLK_DIV - 1)) begin
			div_cnt <= 8'h00;
			div_clk <= ~div_clk;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// mode is a strap; switching it live may glitch the port clock
	assign pclk = mode_s ? div_clk : pclk_in;
	assign pclk_out = div_clk;
	assign pclk_oe = mode_s;

	// reset release synchronised to the port clock
	always_ff @(posedge pclk or posedge rst) begin
		if (rst) begin
			prst_meta <= 1'b1;
			prst <= 1'b1;
		end else begin
			prst_meta <= 1'b0;
			prst <= prst_meta;
		end
	end

	assign ack_d = {port_c_acknowledge, port_b_acknowledge,
		port_a_acknowledge};

	// ------------------------------------------------------------
	// per-port core side capture and link logic
	// ------------------------------------------------------------
	pops_sync #(.WIDTH(NP)) u_done (
		.clk(clk),
		.rst(rst),
		.din(done_toggle),
		.dout(done_s)
	);

	assign busy = load_toggle ^ done_seen;
	assign word_ready = ~busy;

	for (genvar i = 0; i < NP; i++) begin : g_port
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				load_toggle[i] <= 1'b0;
				done_seen[i] <= 1'b0;
				hold_word[i] <= '0;
			end else begin
				if (done_s[i] != done_seen[i])
					done_seen[i] <= done_s[i];
				if (word_valid[i] && !busy[i]) begin
					// tag, iq and gain ride with their word
					hold_word[i] <= {word_gain[i], word_inphase[i],
						word_channel[i*CW +: CW],
						word_data[i*DW +: DW]};
					load_toggle[i] <= ~load_toggle[i];
				end
			end
		end

		// port C uses the identical port instance
		pops_port u_port (
			.pclk(pclk),
			.prst(prst),
			.load_toggle(load_toggle[i]),
			.load_word(hold_word[i]),
			.done_toggle(done_toggle[i]),
			.data_bus(bus_d[i]),
			.channel_tag(tag_d[i]),
			.inphase_flag(iq_d[i]),
			.gain_word_flag(gain_d[i]),
			.request(req_d[i]),
			.acknowledge(ack_d[i])
		);
	end

	assign port_a_data_bus = bus_d[0];
	assign port_a_channel_tag = tag_d[0];
	assign port_a_inphase_flag = iq_d[0];
	assign port_a_gain_word_flag = gain_d[0];
	assign port_a_request = req_d[0];
	assign port_b_data_bus = bus_d[1];
	assign port_b_channel_tag = tag_d[1];
	assign port_b_inphase_flag = iq_d[1];
	assign port_b_gain_word_flag = gain_d[1];
	assign port_b_request = req_d[1];
	assign port_c_data_bus = bus_d[2];
	assign port_c_channel_tag = tag_d[2];
	assign port_c_inphase_flag = iq_d[2];
	assign port_c_gain_word_flag = gain_d[2];
	assign port_c_request = req_d[2];
endmodule

// [verif/pops_asserts.sv]
// port handshake checks for pops_top
// assumes bound to pops_top; port flops seen on the port clock pin
`timescale 1ns/1ps
module pops_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic pclk_in,
	input wire logic master_mode,
	input wire logic pclk_oe,
	input wire logic [2:0] word_valid,
	input wire logic [2:0] word_ready,
	input wire logic [15:0] port_a_data_bus,
	input wire logic [2:0] port_a_channel_tag,
	input wire logic port_a_inphase_flag,
	input wire logic port_a_gain_word_flag,
	input wire logic port_a_request,
	input wire logic port_a_acknowledge,
	input wire logic port_c_request,
	input wire logic port_c_acknowledge
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// port signals live on the port clock; core side on clk
a_hold_data:
	assert property (@(posedge pclk_in)
		port_a_request ##1 port_a_request
		|-> $stable(port_a_data_bus)) else $error("data moved");
a_hold_flags:
	assert property (@(posedge pclk_in)
		port_a_request ##1 port_a_request |-> $stable({
		port_a_channel_tag, port_a_inphase_flag, port_a_gain_word_flag}))
		else $error("flags moved");
a_req_waits:
	assert property (@(posedge pclk_in)
		port_a_request && !port_a_acknowledge
		|=> port_a_request) else $error("request dropped");
a_ack_ends_req:
	assert property (@(posedge pclk_in)
		port_a_request && port_a_acknowledge
		|-> ##[1:4] !port_a_request) else $error("request stuck");
a_portc_waits:
	assert property (@(posedge pclk_in)
		port_c_request && !port_c_acknowledge
		|=> port_c_request) else $error("port c dropped");
a_master_oe:
	assert property (master_mode [*4] |=> pclk_oe) else $error("no oe");
a_slave_oe:
	assert property (!master_mode [*4] |=> !pclk_oe) else $error("oe");
a_accept_busy:
	assert property (word_valid[0] && word_ready[0] |=> !word_ready[0])
		else $error("ready stayed");
cover property (@(posedge pclk_in) port_a_request && port_a_acknowledge);
cover property (@(posedge pclk_in) port_c_request && port_c_acknowledge);
cover property (pclk_oe && port_a_request);
endmodule

// [verif/pops_rx.sv]
// receiver model for one output port, four-phase acknowledge
// assumes pclk is the level on the port clock pin
`timescale 1ns/1ps
module pops_rx #(
	parameter int SLOW = 0
) (
	input wire logic pclk,
	input wire logic rst,
	input wire logic request,
	input wire logic [20:0] word,
	output logic ack,
	output logic [20:0] seen,
	output logic [7:0] cnt
);
logic [3:0] wait_n;
always_ff @(posedge pclk or posedge rst) begin
	if (rst) begin
		ack <= 1'b0;
		wait_n <= 4'h0;
		cnt <= 8'h00;
		seen <= 21'h000000;
	end else if (request && !ack) begin
		if (wait_n >= 4'(SLOW)) begin
			ack <= 1'b1;
			seen <= word;
			cnt <= cnt + 8'h01;
			wait_n <= 4'h0;
		end else begin
			wait_n <= wait_n + 4'h1;
		end
	end else if (!request) begin
		ack <= 1'b0;
	end
end
endmodule

// [verif/tb_top.sv]
// self-checking bench for pops_top, slave then master port clock
// assumes one pops_rx on each port, clocked from the clock pin
`timescale 1ns/1ps
module tb_top;
logic clk, rst, master_mode, lclk, pclk_in, pclk_out, pclk_oe;
logic [2:0] word_valid, word_ready, word_inphase, word_gain, req;
logic [47:0] word_data;
logic [8:0] word_channel;
logic [15:0] port_a_data_bus, port_b_data_bus, port_c_data_bus;
logic [2:0] port_a_channel_tag, port_b_channel_tag, port_c_channel_tag;
logic port_a_inphase_flag, port_b_inphase_flag, port_c_inphase_flag;
logic port_a_gain_word_flag, port_b_gain_word_flag, port_c_gain_word_flag;
logic port_a_request, port_b_request, port_c_request;
logic port_a_acknowledge, port_b_acknowledge, port_c_acknowledge;
logic [20:0] wd [3], pw [3];
wire [20:0] seen [3];
wire [7:0] cnt [3];
wire [2:0] ack;
int err_count, n_compared;
pops_top uut (.*);
assign pclk_in = pclk_oe ? pclk_out : lclk;
assign pw[0] = {port_a_gain_word_flag, port_a_inphase_flag,
	port_a_channel_tag, port_a_data_bus};
assign pw[1] = {port_b_gain_word_flag, port_b_inphase_flag,
	port_b_channel_tag, port_b_data_bus};
assign pw[2] = {port_c_gain_word_flag, port_c_inphase_flag,
	port_c_channel_tag, port_c_data_bus};
assign req = {port_c_request, port_b_request, port_a_request};
assign {port_c_acknowledge, port_b_acknowledge, port_a_acknowledge} = ack;
for (genvar i = 0; i < 3; i++) begin : g_rx
	pops_rx #(.SLOW(i * 3)) rx (.pclk(pclk_in), .rst(rst), .request(req[i]),
		.word(pw[i]), .ack(ack[i]), .seen(seen[i]), .cnt(cnt[i]));
end
always_comb for (int i = 0; i < 3; i++) begin
	word_data[i*16+:16] = wd[i][15:0];
	word_channel[i*3+:3] = wd[i][18:16];
	word_inphase[i] = wd[i][19];
	word_gain[i] = wd[i][20];
end
initial begin
	clk = 1'b0;
	forever #10 clk = ~clk;
end
initial begin
	lclk = 1'b0;
	#7;
	forever #40 lclk = ~lclk;
end
task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
	n_compared++;
	if (g !== e) begin
		$display("unexpected %s expected %h seen %h", n, e, g);
		err_count++;
	end
endtask
// one word through port p, judged at the receiver
task automatic send(input int p, input logic [20:0] w);
	int k;
	logic [7:0] c0;
	@(negedge clk);
	c0 = cnt[p];
	k = 0;
	while (word_ready[p] !== 1'b1 && k < 200) begin
		@(negedge clk);
		k++;
	end
	wd[p] = w;
	word_valid[p] = 1'b1;
	@(negedge clk);
	word_valid[p] = 1'b0;
	while (cnt[p] === c0 && k < 400) begin
		@(negedge clk);
		k++;
	end
	chk("received word", w, seen[p]);
endtask
task t_ports;
	send(0, 21'h12A5C3);
	send(1, 21'h0D3C5A);
	send(2, 21'h1EFFFF);
	$display("test ports done");
endtask
task t_codes;
	for (int i = 0; i < 8; i++)
		send(0, {2'(i), 3'(i), i[0] ? 16'hFFFF : 16'h0000});
	$display("test codes done");
endtask
task t_together;
	fork
		send(0, 21'h0F1234);
		send(1, 21'h158001);
		send(2, 21'h0B7FFE);
	join
	$display("test together done");
endtask
task t_master;
	logic pc;
	@(negedge clk);
	master_mode = 1'b1;
	repeat (8) @(negedge clk);
	chk("clock enable", 21'h000001, {20'h00000, pclk_oe});
	pc = pclk_out;
	repeat (2) @(negedge clk);
	chk("port clock", {20'h00000, ~pc}, {20'h00000, pclk_out});
	send(1, 21'h1C0DE1);
	master_mode = 1'b0;
	repeat (8) @(negedge clk);
	chk("clock enable", 21'h000000, {20'h00000, pclk_oe});
	$display("test master done");
endtask
task test_done;
	$display("compared %0d mismatches %0d", n_compared, err_count);
	if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
initial begin
	rst = 1'b1;
	master_mode = 1'b0;
	word_valid = 3'h0;
	wd = '{default: 21'h000000};
	err_count = 0;
	n_compared = 0;
	repeat (6) @(negedge clk);
	rst = 1'b0;
	t_ports();
	t_codes();
	t_together();
	t_master();
	test_done();
end
initial begin
	#200000;
	err_count++;
	test_done();
end
endmodule
bind pops_top pops_chk chk_i (.*);
